// ==== dv/ppu_core_tb_top.sv ====
// Self-checking bench for the protection unit, driven over its Wishbone port
`timescale 1ns/100ps
`include "ppu_map.svh"
module ppu_core_tb_top
  import ppu_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] st;
  int fail_count = 0;
  int tests_run = 0;

  // Clock at 20 MHz
  always #25 clk_i = ~clk_i;

  ppu_core u_ppu_core (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    wb_sel_i <= s;
    for (n = 0; n < 16 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: no bus answer", $time);
      test_done();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic [31:0] r;
    wb(1'b1, a, dt, 4'hF, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hF, r);
    chk(r, exp, m);
  endtask : rchk

  // Start an operation and poll until it has finished
  task automatic go(input logic [31:0] ctrl);
    int n;
    wr(`PPU_A_CTRL, ctrl);
    for (n = 0; n < 32; n++) begin
      wb(1'b0, `PPU_A_STAT, 32'h0, 4'hF, st);
      if (st[0] === 1'b0 && st[1] === 1'b1) break;
    end
    if (n >= 32) begin
      fail_count++;
      $display("wrong value at %0t: operation never done", $time);
      test_done();
    end
  endtask : go

  // Clear the handled exception, load operands, run the operation
  task automatic run(input logic [31:0] ctrl, input logic [15:0] cs, input logic [15:0] sel,
                     input logic [15:0] desc, input logic [31:0] opnd, input logic [15:0] lim);
    logic [31:0] r;
    wb(1'b1, `PPU_A_CTRL, 32'h0000_0800, 4'h2, r);
    wr(`PPU_A_CS, {16'h0, cs});
    wr(`PPU_A_SEL, {16'h0, sel});
    wr(`PPU_A_DESC, {16'h0, desc});
    wr(`PPU_A_OPND, opnd);
    wr(`PPU_A_LIMIT, {16'h0, lim});
    go(ctrl);
  endtask : run

  // Integer fields take plain literals; each is cut to its register width on purpose
  task automatic tc(input logic [31:0] ctrl, input int cs, input int sel, input int desc,
                    input logic [31:0] opnd, input int lim, input int f, input int v);
    run(ctrl, 16'(cs), 16'(sel), 16'(desc), opnd, 16'(lim));
    chk(32'(st[2]), 32'(f), "fault flag");
    if (f) chk(32'(st[11:4]), 32'(v), "vector");
  endtask : tc

  // Descriptor word: count, gate target level, type, conforming, present, level
  function automatic logic [15:0] dsc(input logic [1:0] l, input logic [3:0] t,
      input logic c = 1'b0, input logic [1:0] g = 2'h0, input logic [4:0] w = 5'h0);
    dsc = {1'b0, w, g, t, c, 1'b1, l};
  endfunction : dsc

  task automatic t_reset();
    rchk(`PPU_A_FLAGS, 32'h0000_0002, "flags reset");
    rchk(`PPU_A_MSW, 32'h0, "status word reset");
    rchk(`PPU_A_STAT, 32'h0, "status reset");
    wr(8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_xfer();
    int l;
    tc(32'h1, 16'h0012, 16'h0040, dsc(2'h1, `PPU_T_CODE_RX, 1'b1), 0, 0, 0, 0);
    tc(32'h1, 16'h0012, 16'h0040, dsc(2'h3, `PPU_T_CODE_RX, 1'b1), 0, 0, 1, `PPU_VEC_GP);
    rchk(`PPU_A_ERR, 32'h0040, "error code");
    rchk(`PPU_A_CS, 32'h0012, "code selector kept");
    tc(32'h1, 16'h0012, 16'h0040, dsc(2'h2, `PPU_T_CODE_RX), 0, 0, 0, 0);
    tc(32'h1, 16'h0012, 16'h0040, dsc(2'h1, `PPU_T_CODE_RX), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h1, 16'h0012, 16'h0040, dsc(2'h2, `PPU_T_DATA_RW), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h2, 16'h0012, 16'h0050, dsc(2'h1, `PPU_T_GATE_CALL, 1'b0, 2'h0),
       0, 0, 1, `PPU_VEC_GP);
    tc(32'h2, 16'h0012, 16'h0050, dsc(2'h3, `PPU_T_GATE_CALL, 1'b0, 2'h3),
       0, 0, 1, `PPU_VEC_GP);
    for (l = 0; l < 3; l++) begin
      tc(32'h2, 16'h0013, 16'h0050, dsc(2'h3, `PPU_T_GATE_CALL, 1'b0, 2'(l), 5'(l + 3)),
         0, 0, 0, 0);
      chk(32'(st[14:12]), 32'({l[1:0], 1'b1}), "stack switch level");
      chk(32'(st[21:17]), 32'(l + 3), "parameter words");
    end
    wr(`PPU_A_FLAGS, 32'h0000_4002);
    tc(32'h3, 16'h0012, 16'h0050, dsc(2'h3, `PPU_T_GATE_INT, 1'b0, 2'h0), 0, 0, 0, 0);
    rchk(`PPU_A_FLAGS, 32'h0000_0002, "nested flag cleared");
    tc(32'h4, 16'h0012, 16'h0041, dsc(2'h1, `PPU_T_CODE_RX), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h4, 16'h0012, 16'h0043, dsc(2'h3, `PPU_T_CODE_RX), 0, 0, 0, 0);
    $display("test transfers done");
  endtask : t_xfer

  task automatic t_flags();
    wr(`PPU_A_FLAGS, 32'h0000_0002);
    tc(32'hC, 16'h0003, 0, 0, 32'h0000_6202, 0, 0, 0);
    rchk(`PPU_A_FLAGS, 32'h0000_0002, "flag restore at outer level");
    tc(32'hC, 16'h0000, 0, 0, 32'h0000_6202, 0, 0, 0);
    rchk(`PPU_A_FLAGS, 32'h0000_6202, "flag restore at level 0");
    tc(32'hB, 16'h0003, 0, 0, 0, 0, 0, 0);
    wr(`PPU_A_FLAGS, 32'h0000_2002);
    tc(32'hB, 16'h0001, 0, 0, 0, 0, 0, 0);
    tc(32'hB, 16'h0002, 16'h0044, 0, 0, 0, 1, `PPU_VEC_GP);
    rchk(`PPU_A_ERR, 32'h0, "no selector error");
    tc(32'hA, 16'h0000, 0, 0, 0, 0, 0, 0);
    tc(32'hA, 16'h0001, 0, 0, 0, 0, 1, `PPU_VEC_GP);
    chk(32'(st[3]), 32'h1, "error code pushed");
    go(32'hA);
    chk(32'(st[11:4]), 32'(`PPU_VEC_DF), "double fault");
    tc(32'h11, 16'h0000, 0, 0, 0, 0, 1, `PPU_VEC_SO);
    chk(32'(st[3]), 32'h0, "no error code");
    $display("test flags and privilege done");
  endtask : t_flags

  task automatic t_seg();
    logic [15:0] sp [4] = '{16'h0000, 16'h0001, 16'hFFFE, 16'hFFFF};
    tc(32'h6, 16'h0000, 16'h0040, dsc(2'h0, `PPU_T_CODE_XO), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h6, 16'h0000, 16'h0040, dsc(2'h0, `PPU_T_GATE_CALL), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h6, 16'h0000, 16'h0040, dsc(2'h3, `PPU_T_DATA_RW), 0, 0, 0, 0);
    tc(32'h106, 16'h0000, 16'h0040, dsc(2'h3, `PPU_T_DATA_RW), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h6, 16'h0000, 16'h0043, dsc(2'h0, `PPU_T_DATA_RW), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h6, 16'h0000, 16'h0040, dsc(2'h3, `PPU_T_DATA_RW) & 16'hFFFB, 0, 0, 1,
       `PPU_VEC_NP);
    tc(32'h7, 16'h0000, 16'h0040, dsc(2'h0, `PPU_T_DATA_RW) & 16'hFFFB, 0, 0, 1,
       `PPU_VEC_SS);
    tc(32'h7, 16'h0000, 16'h0040, dsc(2'h0, `PPU_T_DATA_RO), 0, 0, 1, `PPU_VEC_GP);
    tc(32'h9, 16'h0000, 16'h0040, dsc(2'h3, `PPU_T_DATA_RO), 32'h10, 16'hFF, 1, `PPU_VEC_GP);
    tc(32'h9, 16'h0000, 16'h0040, dsc(2'h3, `PPU_T_CODE_RX), 32'h10, 16'hFF, 1, `PPU_VEC_GP);
    tc(32'h8, 16'h0000, 16'h0040, dsc(2'h3, `PPU_T_CODE_XO), 32'h10, 16'hFF, 1, `PPU_VEC_GP);
    tc(32'h8, 0, 16'h0040, dsc(2'h3, `PPU_T_DATA_RW), 32'h0200_0000, 16'hFF, 1, `PPU_VEC_GP);
    tc(32'h208, 0, 16'h0040, dsc(2'h3, `PPU_T_DATA_RW), 32'h0200_0000, 16'hFF, 1,
       `PPU_VEC_SS);
    tc(32'h8, 0, 16'h0040, dsc(2'h3, `PPU_T_DATA_RW), 32'h0002_FFFF, 16'hFF, 0, 0);
    foreach (sp[i]) begin
      run(32'h10, 16'h0000, 16'h0, 16'h0, {16'h0, sp[i]}, 16'h0);
      chk(32'(st[15]), 32'h1, "non-restartable");
    end
    run(32'h10, 16'h0000, 16'h0, 16'h0, 32'h0000_1234, 16'h0);
    chk(32'(st[15]), 32'h0, "restartable");
    $display("test segments done");
  endtask : t_seg

  task automatic t_task();
    tc(32'hE, 16'h0000, 16'h0030, dsc(2'h0, `PPU_TSS_FREE), 0, 16'h0050, 0, 0);
    rchk(`PPU_A_TR, 32'h0050_0030, "task register");
    tc(32'hE, 16'h0000, 16'h0038, dsc(2'h0, `PPU_TSS_FREE), 0, 16'h002B, 1, `PPU_VEC_TS);
    rchk(`PPU_A_TR, 32'h0050_0030, "task register kept");
    tc(32'hD, 16'h0000, 16'h0048, dsc(2'h0, `PPU_TSS_BUSY), 0, 16'h002C, 1, `PPU_VEC_GP);
    tc(32'h40D, 16'h0000, 16'h0048, dsc(2'h3, `PPU_TSS_FREE), 0, 16'h002C, 0, 0);
    rchk(`PPU_A_TR, 32'h002C_0048, "new task");
    rchk(`PPU_A_LINK, 32'h0033_0030, "link and busy marks");
    rchk(`PPU_A_FLAGS, 32'h0000_4000, "nested flag set");
    rchk(`PPU_A_MSW, 32'h0000_0008, "task switched flag");
    wr(`PPU_A_MSW, 32'h0000_000A);
    tc(32'hF, 16'h0000, 0, 0, 0, 0, 1, `PPU_VEC_NM);
    wr(`PPU_A_MSW, 32'h0000_0002);
    tc(32'hF, 16'h0000, 0, 0, 0, 0, 0, 0);
    wr(`PPU_A_FLAGS, 32'h0000_0002);
    tc(32'h5, 16'h0012, 16'h0043, dsc(2'h3, `PPU_T_CODE_RX), 0, 0, 0, 0);
    rchk(`PPU_A_TR, 32'h002C_0048, "plain return keeps task");
    wr(`PPU_A_FLAGS, 32'h0000_4002);
    tc(32'h5, 16'h0000, 16'h0030, dsc(2'h3, `PPU_TSS_BUSY), 0, 16'h0050, 0, 0);
    rchk(`PPU_A_LINK, 32'h0031_0030, "nested return frees old task");
    rchk(`PPU_A_TR, 32'h0050_0030, "nested return switches task");
    $display("test task switch done");
  endtask : t_task

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_xfer();
    t_flags();
    t_seg();
    t_task();
    test_done();
  end
endmodule : ppu_core_tb_top

// ==== verilog/ppu_core.sv ====
// Protection checker and task switch sequencer behind a Wishbone slave
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module ppu_core
  import ppu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  `include "ppu_map.svh"

  ppu_st_t q, d;
  logic [1:0] current_priv_level, requested_priv_level, effective_priv_level, descriptor_priv_level, tdpl, io_priv_field;
  logic [3:0] ty;
  logic pres, conf;
  logic [15:0] eoff, sp, fsel;
  logic gp, np, ss, ts, nm, so, any, has_err;
  logic [7:0] vec;
  logic [15:0] err;
  logic [31:0] rv, wv;
  logic wr_take;

  // Byte-lane merge of a write into the current register value
  function automatic logic [31:0] wmrg(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmrg

  function automatic logic is_code(input logic [3:0] t);
    return (t == `PPU_T_CODE_XO) || (t == `PPU_T_CODE_RX);
  endfunction : is_code

  function automatic logic is_data(input logic [3:0] t);
    return (t == `PPU_T_DATA_RO) || (t == `PPU_T_DATA_RW);
  endfunction : is_data

  // Flag image masked by privilege before it is restored
  function automatic logic [15:0] fmask(input logic [15:0] o, input logic [15:0] n,
                                        input logic [1:0] c, input logic [1:0] io);
    logic [15:0] r;
    r = n;
    if (c > io) begin
      r[`PPU_FL_IF] = o[`PPU_FL_IF];
    end
    if (c != 2'h0) begin
      r[`PPU_FL_IO_PRIV_FIELD_HI:`PPU_FL_IO_PRIV_FIELD_LO] = o[`PPU_FL_IO_PRIV_FIELD_HI:`PPU_FL_IO_PRIV_FIELD_LO];
    end
    return r;
  endfunction : fmask

  // Privilege levels and descriptor fields
  assign current_priv_level = q.cs_sel[1:0];
  assign requested_priv_level = q.sel[1:0];
  assign effective_priv_level = (requested_priv_level > current_priv_level) ? requested_priv_level : current_priv_level;
  assign descriptor_priv_level = q.desc[1:0];
  assign pres = q.desc[2];
  assign conf = q.desc[3];
  assign ty = q.desc[7:4];
  assign tdpl = q.desc[9:8];
  assign io_priv_field = q.flags[`PPU_FL_IO_PRIV_FIELD_HI:`PPU_FL_IO_PRIV_FIELD_LO];
  assign eoff = q.opnd[15:0] + q.opnd[31:16];
  assign sp = q.opnd[15:0];
  assign fsel = (q.op inside {OP_PRIV, OP_IO}) ? 16'h0000 : q.sel;
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;

  // Protection checks for the pending operation
  always_comb begin
    gp = 1'b0;
    np = 1'b0;
    ss = 1'b0;
    ts = 1'b0;
    nm = 1'b0;
    so = 1'b0;
    case (q.op)
      OP_JMPC: begin
        if (!is_code(ty)) gp = 1'b1;
        else if (conf ? (descriptor_priv_level > current_priv_level) : ((descriptor_priv_level != current_priv_level) || (requested_priv_level > current_priv_level))) gp = 1'b1;
        else if (!pres) np = 1'b1;
      end
      OP_CALLG, OP_INTG: begin
        if (ty != `PPU_T_GATE_CALL && ty != `PPU_T_GATE_INT) gp = 1'b1;
        else if ((descriptor_priv_level < current_priv_level) || (tdpl > current_priv_level)) gp = 1'b1;
        else if (!pres) np = 1'b1;
      end
      OP_RET, OP_RETURN_FROM_INTERRUPT: begin
        if (!(q.op == OP_RETURN_FROM_INTERRUPT && q.flags[`PPU_FL_NT])) begin
          if (!is_code(ty) || (descriptor_priv_level < current_priv_level) || (requested_priv_level < current_priv_level)) gp = 1'b1;
          else if (!pres) np = 1'b1;
        end
      end
      OP_LDS: begin
        if (!is_data(ty) && ty != `PPU_T_CODE_RX) gp = 1'b1;
        else if (!(ty == `PPU_T_CODE_RX && conf) && (descriptor_priv_level < effective_priv_level)) gp = 1'b1;
        else if (!pres) np = 1'b1;
      end
      OP_LSS: begin
        if (ty != `PPU_T_DATA_RW || descriptor_priv_level != current_priv_level || requested_priv_level != current_priv_level) gp = 1'b1;
        else if (!pres) ss = 1'b1;
      end
      OP_RD, OP_WR: begin
        if (q.op == OP_RD && ty == `PPU_T_CODE_XO) gp = 1'b1;
        else if (q.op == OP_WR && (is_code(ty) || ty == `PPU_T_DATA_RO)) gp = 1'b1;
        else if (eoff > q.limit) begin
          if (q.stkseg) ss = 1'b1;
          else gp = 1'b1;
        end
      end
      OP_PRIV: gp = (current_priv_level != 2'h0);
      OP_IO: gp = (current_priv_level > io_priv_field);
      OP_TASK: begin
        if (ty == `PPU_TSS_BUSY) gp = 1'b1;
        else if (ty != `PPU_TSS_FREE && ty != `PPU_T_GATE_TASK) gp = 1'b1;
        else if (descriptor_priv_level < current_priv_level) gp = 1'b1;
        else if (!pres) np = 1'b1;
        else if (q.limit <= `PPU_TSS_MIN_LIM) ts = 1'b1;
      end
      OP_LTR: begin
        if (current_priv_level != 2'h0 || ty != `PPU_TSS_FREE) gp = 1'b1;
        else if (!pres) np = 1'b1;
        else if (q.limit <= `PPU_TSS_MIN_LIM) ts = 1'b1;
      end
      OP_ESC: nm = q.machine_status_word[`PPU_MSW_TS] & q.machine_status_word[`PPU_MSW_MP];
      OP_STKW: ss = 1'b1;
      OP_OVR: so = 1'b1;
      default: ;
    endcase
    // Table overrun outranks the selector checks of jumps, gates, segment loads and task switches (not returns or OP_LTR)
    if (q.tblovr && q.op inside {OP_JMPC, OP_CALLG, OP_INTG, OP_LDS, OP_LSS, OP_TASK}) begin
      gp = 1'b1;
      np = 1'b0;
      ss = 1'b0;
      ts = 1'b0;
    end
  end

  ppu_fault_enc u_enc (
    .gp_i(gp),
    .np_i(np),
    .ss_i(ss),
    .ts_i(ts),
    .nm_i(nm),
    .so_i(so),
    .dbl_i(q.in_exc),
    .sel_i(fsel),
    .any_o(any),
    .vec_o(vec),
    .err_o(err),
    .has_err_o(has_err)
  );

  // Read mux of the register map
  always_comb begin
    case (wb_adr_i)
      `PPU_A_CTRL: rv = {21'h000000, q.nest, q.stkseg, q.tblovr, 3'h0, q.op};
      `PPU_A_CS: rv = {16'h0000, q.cs_sel};
      `PPU_A_SEL: rv = {16'h0000, q.sel};
      `PPU_A_DESC: rv = {16'h0000, q.desc};
      `PPU_A_FLAGS: rv = {16'h0000, q.flags};
      `PPU_A_MSW: rv = {16'h0000, q.machine_status_word};
      `PPU_A_OPND: rv = q.opnd;
      `PPU_A_LIMIT: rv = {16'h0000, q.limit};
      `PPU_A_STAT: rv = {10'h000, q.words, q.in_exc, q.nonrst, q.stk_lvl, q.stk_sw,
                         q.vec, q.has_err, q.fault, q.done, (q.state != S_IDLE)};
      `PPU_A_ERR: rv = {16'h0000, q.err};
      `PPU_A_TR: rv = {q.tr_lim, q.tr_sel};
      `PPU_A_LINK: rv = {8'h00, q.ntype, q.otype, q.link};
      default: rv = 32'h00000000;
    endcase
    wv = wmrg(rv, wb_dat_i, wb_sel_i);
  end

  // Next state: bus slave, register writes and the check sequencer
  always_comb begin
    d = q;
    d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.rdat = rv;
    end
    if (wr_take) begin
      case (wb_adr_i)
        `PPU_A_CTRL: begin
          if (wb_sel_i[1] && wv[`PPU_C_EXCDONE]) d.in_exc = 1'b0;
          if (q.state == S_IDLE && wb_sel_i[0]) begin
            d.op = ppu_op_t'(wv[4:0]);
            d.tblovr = wv[`PPU_C_TBLOVR];
            d.stkseg = wv[`PPU_C_STKSEG];
            d.nest = wv[`PPU_C_NEST];
            d.state = S_CHECK;
            d.done = 1'b0;
          end
        end
        `PPU_A_CS: d.cs_sel = wv[15:0];
        `PPU_A_SEL: d.sel = wv[15:0];
        `PPU_A_DESC: d.desc = wv[15:0];
        `PPU_A_FLAGS: d.flags = wv[15:0];
        `PPU_A_MSW: d.machine_status_word = wv[15:0];
        `PPU_A_OPND: d.opnd = wv;
        `PPU_A_LIMIT: d.limit = wv[15:0];
        default: ;
      endcase
    end
    case (q.state)
      S_IDLE: ;
      S_CHECK: begin
        d.fault = any;
        d.vec = any ? vec : 8'h00;
        d.err = any ? err : 16'h0000;
        d.has_err = any & has_err;
        d.stk_sw = 1'b0;
        d.nonrst = 1'b0;
        d.state = S_IDLE;
        d.done = 1'b1;
        if (any) begin
          d.in_exc = 1'b1;
          d.nonrst = (q.op == OP_STKW) && (sp == 16'h0000 || sp == 16'h0001 ||
                     sp == 16'hFFFE || sp == 16'hFFFF);
        end else begin
          case (q.op)
            OP_JMPC: d.cs_sel = {q.sel[15:2], current_priv_level};
            OP_CALLG, OP_INTG: begin
              d.cs_sel = {q.sel[15:2], tdpl};
              d.stk_sw = (tdpl != current_priv_level);
              d.stk_lvl = tdpl;
              d.words = (q.op == OP_CALLG) ? q.desc[14:10] : 5'h00;
              if (q.op == OP_INTG) d.flags[`PPU_FL_NT] = 1'b0;
            end
            OP_RET, OP_RETURN_FROM_INTERRUPT: begin
              if (q.op == OP_RETURN_FROM_INTERRUPT && q.flags[`PPU_FL_NT]) begin
                d.nest = 1'b0;
                d.done = 1'b0;
                d.state = S_TSW_OLD;
              end else begin
                d.cs_sel = q.sel;
                d.stk_sw = (requested_priv_level != current_priv_level);
                d.stk_lvl = requested_priv_level;
                if (q.op == OP_RETURN_FROM_INTERRUPT) d.flags = fmask(q.flags, q.opnd[15:0], current_priv_level, io_priv_field);
              end
            end
            OP_POP_FLAGS: d.flags = fmask(q.flags, q.opnd[15:0], current_priv_level, io_priv_field);
            OP_LTR: begin
              d.tr_sel = q.sel;
              d.tr_lim = q.limit;
            end
            OP_TASK: begin
              d.done = 1'b0;
              d.state = S_TSW_OLD;
            end
            default: ;
          endcase
        end
      end
      S_TSW_OLD: begin
        d.otype = q.nest ? `PPU_TSS_BUSY : `PPU_TSS_FREE;
        if (q.nest) d.link = q.tr_sel;
        d.state = S_TSW_NEW;
      end
      S_TSW_NEW: begin
        d.ntype = `PPU_TSS_BUSY;
        d.tr_sel = q.sel;
        d.tr_lim = q.limit;
        d.flags = q.opnd[15:0];
        if (q.nest) d.flags[`PPU_FL_NT] = 1'b1;
        d.machine_status_word[`PPU_MSW_TS] = 1'b1;
        d.done = 1'b1;
        d.state = S_IDLE;
      end
      default: d.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.flags <= `PPU_RST_FLAGS;
      q.machine_status_word <= `PPU_RST_MSW;
      q.cs_sel <= `PPU_RST_CS;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_chk(ppu_op_t o);
    q.state == S_CHECK && q.op == o && !q.in_exc && !q.tblovr;
  endsequence
  sequence s_tsw_walk;
    q.state == S_TSW_OLD ##1 q.state == S_TSW_NEW ##1
      (q.done && q.ntype == `PPU_TSS_BUSY && q.machine_status_word[`PPU_MSW_TS]);
  endsequence

  a_priv_instr_gp: assert property (s_chk(OP_PRIV) and (current_priv_level != 2'h0) |=>
    q.fault && q.vec == 8'h0D && q.err == 16'h0000) else $error("privileged op not trapped");
  a_io_level_gp: assert property (s_chk(OP_IO) and (current_priv_level > io_priv_field) |=>
    q.fault && q.vec == 8'h0D) else $error("io op above io level not trapped");
  a_conf_jump_gp: assert property (s_chk(OP_JMPC) and (is_code(ty) && conf && descriptor_priv_level > current_priv_level)
    |=> q.fault && q.cs_sel == $past(q.cs_sel)) else $error("conforming jump not refused");
  a_ret_inward_gp: assert property (s_chk(OP_RET) and (is_code(ty) && descriptor_priv_level < current_priv_level)
    |=> q.fault && q.vec == 8'h0D) else $error("inward return not refused");
  a_esc_after_sw: assert property (s_chk(OP_ESC) and
    (q.machine_status_word[`PPU_MSW_TS] && q.machine_status_word[`PPU_MSW_MP]) |=> q.vec == 8'h07 && !q.has_err)
    else $error("coprocessor use after switch not trapped");
  a_task_walk: assert property (s_chk(OP_TASK) and !any |=> s_tsw_walk)
    else $error("task switch steps wrong");
  a_nest_link: assert property (q.state == S_TSW_OLD && q.nest |=>
    q.link == $past(q.tr_sel) && q.otype == `PPU_TSS_BUSY) else $error("back link not written");
  a_pop_flags_if_keep: assert property (s_chk(OP_POP_FLAGS) and (current_priv_level > io_priv_field) |=>
    q.flags[`PPU_FL_IF] == $past(q.flags[`PPU_FL_IF])) else $error("interrupt flag changed");
  a_pop_flags_io_keep: assert property (s_chk(OP_POP_FLAGS) and (current_priv_level != 2'h0) |=>
    io_priv_field == $past(io_priv_field) && !q.fault) else $error("io level field changed");
  a_fault_no_side: assert property (q.state == S_CHECK && any |=>
    q.cs_sel == $past(q.cs_sel) && q.flags == $past(q.flags) && !q.stk_sw)
    else $error("faulting op changed state");
  a_wrap_nonrst: assert property (s_chk(OP_STKW) and (sp == 16'hFFFF) |=>
    q.nonrst && q.vec == 8'h0C) else $error("wrap not flagged");
  a_stack_switch: assert property (s_chk(OP_CALLG) and !any and (tdpl != current_priv_level) |=>
    q.stk_sw && q.stk_lvl == $past(tdpl) && q.cs_sel[1:0] == $past(tdpl))
    else $error("stack not switched");
endmodule : ppu_core

// ==== verilog/ppu_fault_enc.sv ====
// Fault encoder: picks the exception vector and error code
`timescale 1ns/100ps
module ppu_fault_enc
  import ppu_pkg::*;
(
  input wire logic gp_i,
  input wire logic np_i,
  input wire logic ss_i,
  input wire logic ts_i,
  input wire logic nm_i,
  input wire logic so_i,
  input wire logic dbl_i,
  input wire logic [15:0] sel_i,
  output logic any_o,
  output logic [7:0] vec_o,
  output logic [15:0] err_o,
  output logic has_err_o
);
  `include "ppu_map.svh"

  // Second fault during handling becomes a double fault with a zero code
  always_comb begin
    any_o = gp_i | np_i | ss_i | ts_i | nm_i | so_i;
    has_err_o = 1'b1;
    err_o = {sel_i[15:2], 2'h0};
    vec_o = `PPU_VEC_GP;
    if (dbl_i) begin
      vec_o = `PPU_VEC_DF;
      err_o = 16'h0000;
    end else if (so_i) begin
      vec_o = `PPU_VEC_SO;
      has_err_o = 1'b0;
      err_o = 16'h0000;
    end else if (nm_i) begin
      vec_o = `PPU_VEC_NM;
      has_err_o = 1'b0;
      err_o = 16'h0000;
    end else if (ts_i) begin
      vec_o = `PPU_VEC_TS;
    end else if (np_i) begin
      vec_o = `PPU_VEC_NP;
    end else if (ss_i) begin
      vec_o = `PPU_VEC_SS;
    end
  end
endmodule : ppu_fault_enc

// ==== verilog/ppu_map.svh ====
// Register offsets, field positions, reset values and codes of the protection unit
`ifndef PPU_MAP_SVH
`define PPU_MAP_SVH
`define PPU_A_CTRL 8'h00
`define PPU_A_CS 8'h04
`define PPU_A_SEL 8'h08
`define PPU_A_DESC 8'h0C
`define PPU_A_FLAGS 8'h10
`define PPU_A_MSW 8'h14
`define PPU_A_OPND 8'h18
`define PPU_A_LIMIT 8'h1C
`define PPU_A_STAT 8'h20
`define PPU_A_ERR 8'h24
`define PPU_A_TR 8'h28
`define PPU_A_LINK 8'h2C
`define PPU_C_TBLOVR 8
`define PPU_C_STKSEG 9
`define PPU_C_NEST 10
`define PPU_C_EXCDONE 11
`define PPU_FL_NT 14
`define PPU_FL_IO_PRIV_FIELD_HI 14
`define PPU_FL_IO_PRIV_FIELD_LO 13
`define PPU_FL_IF 9
`define PPU_MSW_MP 1
`define PPU_MSW_TS 3
`define PPU_RST_FLAGS 16'h0002
`define PPU_RST_MSW 16'h0000
`define PPU_RST_CS 16'h0000
`define PPU_TSS_MIN_LIM 16'h002B
`define PPU_TSS_FREE 4'h1
`define PPU_TSS_BUSY 4'h3
`define PPU_T_DATA_RO 4'h4
`define PPU_T_DATA_RW 4'h5
`define PPU_T_CODE_XO 4'h6
`define PPU_T_CODE_RX 4'h7
`define PPU_T_GATE_CALL 4'h8
`define PPU_T_GATE_TASK 4'h9
`define PPU_T_GATE_INT 4'hA
`define PPU_VEC_NM 8'h07
`define PPU_VEC_DF 8'h08
`define PPU_VEC_SO 8'h09
`define PPU_VEC_TS 8'h0A
`define PPU_VEC_NP 8'h0B
`define PPU_VEC_SS 8'h0C
`define PPU_VEC_GP 8'h0D
`endif

// ==== verilog/ppu_pkg.sv ====
// Types shared by the protection unit modules
package ppu_pkg;
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_TSW_OLD, S_TSW_NEW} ppu_state_t;
  typedef enum logic [4:0] {
    OP_NONE, OP_JMPC, OP_CALLG, OP_INTG, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_LDS, OP_LSS,
    OP_RD, OP_WR, OP_PRIV, OP_IO, OP_POP_FLAGS, OP_TASK, OP_LTR, OP_ESC,
    OP_STKW, OP_OVR
  } ppu_op_t;
  typedef struct packed {
    ppu_state_t state;
    logic ack;
    logic [31:0] rdat;
    ppu_op_t op;
    logic tblovr;
    logic stkseg;
    logic nest;
    logic [15:0] cs_sel;
    logic [15:0] sel;
    logic [15:0] desc;
    logic [15:0] flags;
    logic [15:0] machine_status_word;
    logic [31:0] opnd;
    logic [15:0] limit;
    logic done;
    logic fault;
    logic has_err;
    logic [7:0] vec;
    logic [15:0] err;
    logic stk_sw;
    logic [1:0] stk_lvl;
    logic [4:0] words;
    logic nonrst;
    logic in_exc;
    logic [15:0] tr_sel;
    logic [15:0] tr_lim;
    logic [15:0] link;
    logic [3:0] otype;
    logic [3:0] ntype;
  } ppu_st_t;
endpackage : ppu_pkg
